//--- include/dio_pkg.sv
/*
 * Shared constants for the digital input/output and counter front end:
 * peripheral addresses, pin roles, mode encodings and filter timing.
 * Assumes a single 25 MHz clock; all users import the whole package.
 */
// Notes on behaviour
// - Fast inputs raise interrupt on chosen edge
// - Third input byte never raises interrupts
// - Only diagnostic event: hardware interrupt lost
// - Delay filter setting shared per four inputs
// - 0.1ms code honoured, others give 0.35ms
// - Counters and plain I/O run together
// - Counter inputs stay readable as input bits
// - Counter-owned outputs ignore program writes
// - Three counters: continuous, single, periodic modes
// - Counting up to 30kHz, all counters alike
// - Each counter value is one double word
// - End value up, start value down
// - Gate, latch, compare, hysteresis, interrupt per counter
// - Counter pins from bits 0.0-1.0, latches 1.4-1.6
// - Counter outputs drive output bits 0.0-0.2
// - Output indicators follow outputs; fault indicator separate
// - Without configuration default addresses are used
// - Input bytes at 124, 125, 126
// - Output bytes at 124, 125
// - Counter values at 768, 772, 776
package dio_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int NUM_IN      = 24;            // Input pins, three bytes
	localparam int NUM_IRQ_IN  = 16;            // Inputs that may raise events
	localparam int NUM_OUT     = 16;            // Output pins, two bytes
	localparam int NUM_CH      = 3;             // Counter channels
	localparam int GROUP_SIZE  = 4;             // Inputs sharing one delay code
	localparam int NUM_GROUP   = NUM_IN / GROUP_SIZE;
	localparam int ADDR_W      = 10;            // Peripheral byte address width

	////////////////////////////////////////////////////////////////////////////
	// Peripheral addresses (byte addresses)
	localparam logic [ADDR_W-1:0] IN_ADDR_LOW   = 10'h07c;
	localparam logic [ADDR_W-1:0] IN_ADDR_MID   = 10'h07d;
	localparam logic [ADDR_W-1:0] IN_ADDR_HIGH  = 10'h07e;
	localparam logic [ADDR_W-1:0] OUT_ADDR_LOW  = 10'h07c;
	localparam logic [ADDR_W-1:0] OUT_ADDR_HIGH = 10'h07d;
	localparam logic [ADDR_W-1:0] CNT0_ADDR     = 10'h300;
	localparam logic [ADDR_W-1:0] CNT1_ADDR     = 10'h304;
	localparam logic [ADDR_W-1:0] CNT2_ADDR     = 10'h308;
	localparam logic [ADDR_W-1:0] CNT_SPARE_ADDR = 10'h30c;

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0]  OUT_RESET = 8'h00;
	localparam logic [31:0] CNT_RESET = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////
	// Counter pin roles: pulse, direction, gate in strides of three
	localparam int CH_PIN_STRIDE  = 3;
	localparam int PULSE_PIN_OFS  = 0;
	localparam int DIR_PIN_OFS    = 1;
	localparam int GATE_PIN_OFS   = 2;
	localparam int LATCH_PIN_BASE = 12;         // Input bit 1.4

	////////////////////////////////////////////////////////////////////////////
	// Encodings
	typedef enum logic [1:0] {
		CNT_CONT   = 2'b00,                     // Free running
		CNT_SINGLE = 2'b01,                     // Stops after one pass
		CNT_PERIOD = 2'b10                      // Reloads and keeps going
	} dio_cnt_mode_e;

	localparam logic [1:0] DIR_NONE = 2'b00;    // No main direction
	localparam logic [1:0] DIR_UP   = 2'b01;
	localparam logic [1:0] DIR_DOWN = 2'b10;

	localparam logic [1:0] CMP_NONE = 2'b00;    // Output is a plain output
	localparam logic [1:0] CMP_GE   = 2'b01;    // Set while value >= compare
	localparam logic [1:0] CMP_LE   = 2'b10;    // Set while value <= compare

	localparam logic [2:0] DLY_CODE_FAST = 3'h1; // Code selecting the 0.1ms delay

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,                        // Gate closed
		ST_RUN  = 2'b01,                        // Counting
		ST_DONE = 2'b10                         // Single pass finished
	} dio_cnt_state_e;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int DLY_SHORT_NS  = 100000;      // 0.1 ms
	localparam int DLY_LONG_NS   = 350000;      // 0.35 ms
	localparam int DLY_SHORT_CYC = (DLY_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DLY_LONG_CYC  = (DLY_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

//--- verilog/dio_front_end.sv
/*
 * Digital input/output front end with three counter channels.
 * Holds pin synchronisers, delay filters, edge events, the counters,
 * output muxing and the peripheral read/write port.
 * Assumes pins are asynchronous to clk and the program side is on clk.
 */
`timescale 1ns/1ns
module dio_front_end
	import dio_pkg::*;
#(
	parameter int LONG_CYC = DLY_LONG_CYC        // Long filter count, shortened in sim
)(
	input  wire logic                      clk,
	input  wire logic                      nrst,
	input  wire logic                      ce,
	input  wire logic [NUM_IN-1:0]         inPin,
	input  wire logic                      overloadPin,
	output logic [NUM_OUT-1:0]             outPin,
	output logic [NUM_IN-1:0]              inLed,
	output logic [NUM_OUT-1:0]             outLed,
	output logic                           faultLed,
	input  wire logic                      perRd,
	input  wire logic                      perWr,
	input  wire logic [ADDR_W-1:0]         perAddr,
	input  wire logic [7:0]                perWdata,
	output logic [31:0]                    perRdata,
	output logic                           perRdValid,
	input  wire logic [NUM_IRQ_IN-1:0]     riseIrqEn,
	input  wire logic [NUM_IRQ_IN-1:0]     fallIrqEn,
	input  wire logic [NUM_GROUP-1:0][2:0] delayCode,
	input  wire logic [NUM_CH-1:0][1:0]    cntMode,
	input  wire logic [NUM_CH-1:0][1:0]    mainDir,
	input  wire logic [NUM_CH-1:0]         dirInvert,
	input  wire logic [NUM_CH-1:0][31:0]   limitValue,
	input  wire logic [NUM_CH-1:0][31:0]   cmpValue,
	input  wire logic [NUM_CH-1:0][1:0]    cmpMode,
	input  wire logic [NUM_CH-1:0][15:0]   hystValue,
	input  wire logic [NUM_CH-1:0]         hwGateUse,
	input  wire logic [NUM_CH-1:0]         swGate,
	input  wire logic [NUM_CH-1:0]         cntIrqEn,
	output logic [NUM_CH-1:0][31:0]        latchValue,
	output logic                           hwIrq,
	output logic [NUM_IRQ_IN+NUM_CH-1:0]   hwIrqSrc,
	input  wire logic                      irqAck,
	output logic                           irqLost
);

	localparam int FW = $clog2(LONG_CYC + 1);  // Filter counter width
	localparam int NEV = NUM_IRQ_IN + NUM_CH;  // Event sources

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [NUM_IN-1:0] syncA;                  // First stage, read only by syncB
	logic [NUM_IN-1:0] syncB;                  // Usable pin levels
	logic [NUM_IN-1:0] syncPrev;               // Previous usable levels
	logic              ovlA;                   // Overload first stage
	logic              ovlB;                   // Overload usable level

	// Two flops per pin before any logic looks at it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			syncA    <= '0;
			syncB    <= '0;
			syncPrev <= '0;
			ovlA     <= 1'b0;
			ovlB     <= 1'b0;
		end else if (ce) begin
			syncA    <= inPin;
			syncB    <= syncA;
			syncPrev <= syncB;
			ovlA     <= overloadPin;
			ovlB     <= ovlA;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Input delay filters
	logic [NUM_IN-1:0] filt;                   // Filtered input levels
	logic [NUM_IN-1:0] filtPrev;               // Filtered levels one cycle back
	logic [NUM_IN-1:0] next_filt;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_IN; gi++) begin : g_filt
			logic [FW-1:0] cnt;                // Cycles the new level has held
			logic [FW-1:0] next_cnt;
			logic [FW-1:0] thr;                // Cycles needed to accept it

			// One code per group of four; only the fast code is honoured
			always_comb begin
				thr = (delayCode[gi / GROUP_SIZE] == DLY_CODE_FAST) ?
					FW'(DLY_SHORT_CYC) : FW'(LONG_CYC);
				next_cnt      = '0;
				next_filt[gi] = filt[gi];
				if (syncB[gi] != filt[gi]) begin
					if (cnt + 1'b1 >= thr) begin
						next_filt[gi] = syncB[gi];
					end else begin
						next_cnt = cnt + 1'b1;
					end
				end
			end

			// Counter only; a bounce restarts the wait from zero
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					cnt <= '0;
				end else if (ce) begin
					cnt <= next_cnt;
				end
			end
		end
	endgenerate

	// Filtered levels and their history
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			filt     <= '0;
			filtPrev <= '0;
		end else if (ce) begin
			filt     <= next_filt;
			filtPrev <= filt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Counter channels
	logic [NUM_CH-1:0][31:0] cntValue;         // Live counter values
	logic [NUM_CH-1:0]       cmpOut;           // Comparison output levels
	logic [NUM_CH-1:0]       cntEvent;         // Comparison became true, enabled

	genvar gc;
	generate
		for (gc = 0; gc < NUM_CH; gc++) begin : g_cnt
			localparam int PP = gc * CH_PIN_STRIDE + PULSE_PIN_OFS;
			localparam int DP = gc * CH_PIN_STRIDE + DIR_PIN_OFS;
			localparam int GP = gc * CH_PIN_STRIDE + GATE_PIN_OFS;
			localparam int LP = LATCH_PIN_BASE + gc;

			dio_cnt_state_e state;
			dio_cnt_state_e next_state;
			logic [31:0]    next_value;
			logic           hwOpen;            // Pin gate opened by rising edge
			logic           next_hwOpen;
			logic           next_cmp;
			logic [31:0]    next_latch;
			logic           iGate;             // Internal gate
			logic           pulse;             // Count edge seen
			logic           down;              // Count direction is down
			logic           wrap;              // Range end passed this step
			logic [32:0]    valExt;
			logic [32:0]    cmpExt;

			// Raw synchronised pins; the delay filter would eat 30 kHz pulses
			assign pulse = syncB[PP] & ~syncPrev[PP];
			assign down  = syncB[DP] ^ dirInvert[gc];
			assign iGate = swGate[gc] & (~hwGateUse[gc] | hwOpen);
			assign valExt = {1'b0, cntValue[gc]};
			assign cmpExt = {1'b0, cmpValue[gc]};

			// Counting, gate and latch next values
			always_comb begin
				next_state  = state;
				next_value  = cntValue[gc];
				next_latch  = latchValue[gc];
				wrap        = 1'b0;
				next_hwOpen = hwOpen;
				// Pin gate opens on 0-1, closes on 1-0
				if (syncB[GP] & ~syncPrev[GP]) begin
					next_hwOpen = 1'b1;
				end else if (~syncB[GP] & syncPrev[GP]) begin
					next_hwOpen = 1'b0;
				end
				unique case (state)
					ST_IDLE: begin
						// Limited modes restart their range when the gate opens
						if (iGate) begin
							next_state = ST_RUN;
							if (cntMode[gc] != CNT_CONT) begin
								next_value = (mainDir[gc] == DIR_DOWN) ?
									limitValue[gc] : CNT_RESET;
							end
						end
					end
					ST_RUN: begin
						if (!iGate) begin
							next_state = ST_IDLE;
						end else if (pulse) begin
							if (cntMode[gc] == CNT_CONT) begin
								next_value = down ? cntValue[gc] - 32'h1 :
									cntValue[gc] + 32'h1;
							end else if (mainDir[gc] == DIR_DOWN) begin
								// Start value down to one, then reload
								if (!down) begin
									if (cntValue[gc] < limitValue[gc]) begin
										next_value = cntValue[gc] + 32'h1;
									end
								end else if (cntValue[gc] <= 32'h1) begin
									next_value = limitValue[gc];
									wrap       = 1'b1;
								end else begin
									next_value = cntValue[gc] - 32'h1;
								end
							end else begin
								// Zero up to end value minus one, then reload
								if (down) begin
									if (cntValue[gc] != 32'h0) begin
										next_value = cntValue[gc] - 32'h1;
									end
								end else if (cntValue[gc] + 32'h1 >= limitValue[gc]) begin
									next_value = CNT_RESET;
									wrap       = 1'b1;
								end else begin
									next_value = cntValue[gc] + 32'h1;
								end
							end
							// Single mode stops after its one pass
							if (wrap && cntMode[gc] == CNT_SINGLE) begin
								next_state = ST_DONE;
							end
						end
					end
					ST_DONE: begin
						if (!iGate) begin
							next_state = ST_IDLE;
						end
					end
					default: begin
						next_state = ST_IDLE;
					end
				endcase
				// Latch pin stores the value on its rising edge
				if (syncB[LP] & ~syncPrev[LP]) begin
					next_latch = cntValue[gc];
				end
			end

			// Comparison with hysteresis against the released side
			always_comb begin
				next_cmp = cmpOut[gc];
				unique case (cmpMode[gc])
					CMP_GE: begin
						if (valExt >= cmpExt) begin
							next_cmp = 1'b1;
						end else if (valExt + {17'h0, hystValue[gc]} < cmpExt) begin
							next_cmp = 1'b0;
						end
					end
					CMP_LE: begin
						if (valExt <= cmpExt) begin
							next_cmp = 1'b1;
						end else if (valExt > cmpExt + {17'h0, hystValue[gc]}) begin
							next_cmp = 1'b0;
						end
					end
					default: begin
						next_cmp = 1'b0;
					end
				endcase
			end

			// Counter channel registers
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					state          <= ST_IDLE;
					cntValue[gc]   <= CNT_RESET;
					latchValue[gc] <= CNT_RESET;
					hwOpen         <= 1'b0;
					cmpOut[gc]     <= 1'b0;
				end else if (ce) begin
					state          <= next_state;
					cntValue[gc]   <= next_value;
					latchValue[gc] <= next_latch;
					hwOpen         <= next_hwOpen;
					cmpOut[gc]     <= next_cmp;
				end
			end

			// Event when the comparison turns true
			assign cntEvent[gc] = next_cmp & ~cmpOut[gc] & cntIrqEn[gc];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Hardware interrupt events
	logic [NUM_IRQ_IN-1:0] edgeEvent;          // Enabled filtered edges
	logic [NEV-1:0]        allEvent;
	logic                  next_hwIrq;
	logic [NEV-1:0]        next_src;
	logic                  next_lost;

	// Only the low two bytes, and only after the filter
	assign edgeEvent = (filt[NUM_IRQ_IN-1:0] & ~filtPrev[NUM_IRQ_IN-1:0] & riseIrqEn) |
		(~filt[NUM_IRQ_IN-1:0] & filtPrev[NUM_IRQ_IN-1:0] & fallIrqEn);
	assign allEvent  = {cntEvent, edgeEvent};

	// A new event wins over an acknowledge in the same cycle
	always_comb begin
		next_hwIrq = hwIrq;
		next_src   = hwIrqSrc;
		next_lost  = 1'b0;
		if (|allEvent) begin
			if (hwIrq && !irqAck) begin
				next_lost = 1'b1;
				next_src  = hwIrqSrc | allEvent;
			end else begin
				next_src  = allEvent;
			end
			next_hwIrq = 1'b1;
		end else if (irqAck) begin
			next_hwIrq = 1'b0;
			next_src   = '0;
		end
	end

	// Interrupt registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hwIrq    <= 1'b0;
			hwIrqSrc <= '0;
			irqLost  <= 1'b0;
		end else if (ce) begin
			hwIrq    <= next_hwIrq;
			hwIrqSrc <= next_src;
			irqLost  <= next_lost;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output bytes and indicators
	logic [NUM_OUT-1:0] outReg;                // Program written output image
	logic [NUM_OUT-1:0] next_outReg;
	logic [NUM_OUT-1:0] ownMask;               // Bits taken by counters
	logic [NUM_OUT-1:0] cntDrive;              // Counter levels on their bits
	logic [NUM_OUT-1:0] next_outPin;

	// Channel c owns output bit c while a comparison mode is chosen
	always_comb begin
		ownMask  = '0;
		cntDrive = '0;
		for (int c = 0; c < NUM_CH; c++) begin
			ownMask[c]  = (cmpMode[c] != CMP_NONE);
			cntDrive[c] = cmpOut[c];
		end
	end

	// Writes reach only bits the counters do not own
	always_comb begin
		next_outReg = outReg;
		if (perWr && perAddr == OUT_ADDR_LOW) begin
			next_outReg[7:0] = (perWdata & ~ownMask[7:0]) |
				(outReg[7:0] & ownMask[7:0]);
		end else if (perWr && perAddr == OUT_ADDR_HIGH) begin
			next_outReg[15:8] = perWdata;
		end
		next_outPin = (next_outReg & ~ownMask) | (cntDrive & ownMask);
	end

	// Output pins, indicators and output image
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			outReg   <= {OUT_RESET, OUT_RESET};
			outPin   <= {OUT_RESET, OUT_RESET};
			faultLed <= 1'b0;
		end else if (ce) begin
			outReg   <= next_outReg;
			outPin   <= next_outPin;
			faultLed <= ovlB;
		end
	end

	// Indicators follow the levels actually driven and seen
	assign outLed = outPin;
	assign inLed  = filt;

	////////////////////////////////////////////////////////////////////////////
	// Peripheral read port
	logic [31:0] next_rdata;
	logic        next_rdValid;

	// Fixed default map; unmapped addresses read as zero
	always_comb begin
		next_rdValid = perRd;
		next_rdata   = '0;
		if (perRd) begin
			unique case (perAddr)
				IN_ADDR_LOW:  next_rdata = {24'h0, filt[7:0]};
				IN_ADDR_MID:  next_rdata = {24'h0, filt[15:8]};
				IN_ADDR_HIGH: next_rdata = {24'h0, filt[23:16]};
				CNT0_ADDR:    next_rdata = cntValue[0];
				CNT1_ADDR:    next_rdata = cntValue[1];
				CNT2_ADDR:    next_rdata = cntValue[2];
				default:      next_rdata = '0;
			endcase
		end
	end

	// Read answer one cycle after the strobe
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			perRdata   <= '0;
			perRdValid <= 1'b0;
		end else if (ce) begin
			perRdata   <= next_rdata;
			perRdValid <= next_rdValid;
		end
	end

endmodule // dio_front_end

//--- verif/dio_field_model.sv
/* Field model: switch levels and a pulse encoder.
   Assumes levels and bursts change on the rising edge of clk. */
`timescale 1ns/1ns
module dio_field_model
	import dio_pkg::*;
#(
	parameter int HALF = 4              // Pulse half period in clocks
)(
	input  logic              clk,
	input  logic              nrst,
	input  logic [NUM_IN-1:0] level,    // Switch levels
	input  logic              start,    // Begin a burst
	input  logic [7:0]        count,    // Pulses in the burst
	output logic              busy,     // Burst running
	output logic [NUM_IN-1:0] inPin     // Pins seen by the device
);
	logic [7:0]  left;                  // Pulses still to send
	logic [15:0] tick;                  // Half period timer
	logic        ph;                    // Present pulse level

	////////////////////////////////////////////////////////////////
	// Burst engine; phases stay long enough for the pin synchroniser
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			left <= 8'h00;
			tick <= 16'h0000;
			ph   <= 1'b0;
		end else if (start && left == 8'h00) begin
			left <= count;
			tick <= 16'h0000;
		end else if (left != 8'h00) begin
			// One pulse is a low phase then a high phase
			if (tick == 16'(HALF - 1)) begin
				tick <= 16'h0000;
				ph   <= !ph;
				if (ph)
					left <= left - 8'h01;
			end else begin
				tick <= tick + 16'h0001;
			end
		end
	end

	assign busy = (left != 8'h00);
	// Encoder track on the three pulse pins, switches on the rest
	assign inPin = level | ({NUM_IN{ph}} & 24'h000049);
endmodule // dio_field_model

//--- verif/dio_front_end_sva.sv
/* Checker on the top ports of the digital I/O front end.
   Assumes one clock and one-cycle read answers. */
`timescale 1ns/1ns
module dio_front_end_sva
	import dio_pkg::*;
#(
	parameter int LONG_CYC = DLY_LONG_CYC   // Same filter count as the design
)(
	input logic               clk,
	input logic               nrst,
	input logic               ce,
	input logic               perRd,
	input logic               perWr,
	input logic [ADDR_W-1:0]  perAddr,
	input logic [7:0]         perWdata,
	input logic [31:0]        perRdata,
	input logic               perRdValid,
	input logic [NUM_IN-1:0]  inLed,
	input logic [NUM_OUT-1:0] outPin,
	input logic [NUM_OUT-1:0] outLed,
	input logic               overloadPin,
	input logic               faultLed,
	input logic               hwIrq,
	input logic               irqAck,
	input logic               irqLost
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	////////////////////////////////////////////////////////////////
	// Register port
	a_read_answer: assert property (perRd && ce |=> perRdValid)
		else $error("read strobe gave no valid pulse");
	a_read_quiet: assert property (
		ce && !perRd |=> !perRdValid && perRdata == 32'h0)
		else $error("valid or data without a read");
	a_spare_zero: assert property (
		perRd && ce && perAddr == CNT_SPARE_ADDR |=> perRdata == 32'h0)
		else $error("spare word not zero");
	a_input_byte: assert property (
		(perRd && ce && perAddr == IN_ADDR_LOW) ##1 $stable(inLed)
		|-> perRdata == {24'h000000, inLed[7:0]})
		else $error("low input byte read differs from inputs");
	a_out_high: assert property (
		perWr && ce && perAddr == OUT_ADDR_HIGH |=> outPin[15:8] == $past(perWdata))
		else $error("high output byte not written");
	a_out_low: assert property (
		perWr && ce && perAddr == OUT_ADDR_LOW |=> outPin[7:3] == $past(perWdata[7:3]))
		else $error("plain low output bits not written");

	////////////////////////////////////////////////////////////////
	// Indicators and events
	a_led_out: assert property (outLed == outPin)
		else $error("output indicator differs from output");
	a_fault_led: assert property (
		($stable(overloadPin) && ce) [*5] |-> faultLed == overloadPin)
		else $error("fault indicator does not follow overload");
	a_irq_holds: assert property (hwIrq && !irqAck && ce |=> hwIrq)
		else $error("pending event dropped without acknowledge");
	a_lost_pending: assert property (irqLost |-> $past(hwIrq))
		else $error("lost event flagged with nothing pending");
endmodule // dio_front_end_sva

bind dio_front_end dio_front_end_sva #(.LONG_CYC(LONG_CYC)) dio_front_end_sva_i (.*);

//--- verif/test_digital_io_counter_front_end.sv
/* Self-checking bench for the digital I/O front end.
   Assumes a 25 MHz clock and a shortened slow filter. */
`timescale 1ns/1ns
module test_digital_io_counter_front_end
	import dio_pkg::*;
;
	localparam int LONG = 3000;         // Slow count above fast
	logic                         clk, nrst, perRd, perWr, overloadPin, irqAck, start, busy;
	logic                         faultLed, perRdValid, hwIrq, irqLost, lostSeen, ce;
	logic [ADDR_W-1:0]            perAddr;
	logic [7:0]                   perWdata, count, d;
	logic [31:0]                  perRdata, got;
	logic [NUM_IN-1:0]            inPin, inLed, level;
	logic [NUM_OUT-1:0]           outPin, outLed;
	logic [NUM_IRQ_IN-1:0]        riseIrqEn, fallIrqEn;
	logic [NUM_GROUP-1:0][2:0]    delayCode;
	logic [NUM_CH-1:0][1:0]       cntMode, mainDir, cmpMode;
	logic [NUM_CH-1:0][31:0]      limitValue, cmpValue, latchValue;
	logic [NUM_CH-1:0]            swGate;
	logic [NUM_IRQ_IN+NUM_CH-1:0] hwIrqSrc;
	integer                       errors, n_compared, seed;

	// Direction invert, hysteresis, pin gate and counter events tied
	dio_front_end #(.LONG_CYC(LONG)) dio_front_end_i (.ce(ce), .dirInvert(3'h0),
		.hystValue(48'h0), .hwGateUse(3'h0), .cntIrqEn(3'h0), .*);
	dio_field_model #(.HALF(4)) dio_field_model_i (.*);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Sticky copy of the lost pulse
	always @(posedge clk) if (irqLost) lostSeen <= 1'b1;

	////////////////////////////////////////////////////////////////
	// Helpers
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_compared = n_compared + 1;
		if (g !== e) begin
			errors = errors + 1;
			$display("[FAIL] %0t %s: got %h expected %h", $time, m, g, e);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge clk);
		perRd   <= 1'b1;
		perAddr <= a;
		@(posedge clk);
		perRd <= 1'b0;
		#1;
		got = perRdata;
		chk({31'h0, perRdValid}, 32'h1, "read valid");
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
		@(posedge clk);
		perWr    <= 1'b1;
		perAddr  <= a;
		perWdata <= v;
		@(posedge clk);
		perWr <= 1'b0;
		#1;
	endtask
	task automatic burst(input logic [7:0] n);
		int k;
		@(posedge clk);
		start <= 1'b1;
		count <= n;
		@(posedge clk);
		start <= 1'b0;
		#1;
		for (k = 0; k < 5000 && busy; k++) @(posedge clk);
		idle(8);
	endtask
	// Limited count after n pulses
	function automatic logic [31:0] cnt_exp(input bit sgl, input bit dn, input int n);
		int v;
		bit done;
		v = dn ? 5 : 0;
		done = 1'b0;
		for (int i = 0; i < n; i++) begin
			if (!done && dn) begin
				v = (v == 1) ? 5 : v - 1;
				done = sgl && v == 5;
			end else if (!done) begin
				v = (v == 4) ? 0 : v + 1;
				done = sgl && v == 0;
			end
		end
		return 32'(v);
	endfunction
	task automatic stop_test;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		idle(40000);
		errors = errors + 1;
		$display("[FAIL] %0t watchdog expired", $time);
		stop_test;
	end

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		seed = 32'hc0ca;
		errors = 0;
		n_compared = 0;
		{nrst, perRd, perWr, overloadPin, irqAck, start, lostSeen, swGate} = '0;
		ce = 1'b1;
		{perAddr, perWdata, count, level, riseIrqEn, fallIrqEn} = '0;
		{cntMode, mainDir, cmpMode, limitValue, cmpValue} = '0;
		delayCode = '0;
		delayCode[0] = DLY_CODE_FAST;
		// Slow random codes elsewhere
		for (int g = 1; g < NUM_GROUP; g++) delayCode[g] = 3'($random(seed)) & 3'h6;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		// Random output bytes, then an unmapped write
		for (int i = 0; i < 8; i++) begin
			d = 8'($random(seed));
			wr(i[0] ? OUT_ADDR_HIGH : OUT_ADDR_LOW, d);
			chk({24'h0, i[0] ? outPin[15:8] : outPin[7:0]}, {24'h0, d}, "output byte");
		end
		got = {16'h0, outPin};
		wr(10'h07f, 8'h5a);
		chk({16'h0, outPin}, got, "unmapped write");
		rd(CNT_SPARE_ADDR);
		chk(got, 32'h0, "spare word");
		rd(10'h200);
		chk(got, 32'h0, "unmapped read");
		@(posedge clk) overloadPin <= 1'b1;
		idle(6);
		chk({31'h0, faultLed}, 32'h1, "fault indicator");
		@(posedge clk) overloadPin <= 1'b0;
		// A glitch shorter than the filter raises nothing
		@(posedge clk) riseIrqEn <= 16'h0002;
		level <= 24'h000002;
		repeat (100) @(posedge clk);
		level <= 24'h000000;
		idle(LONG + 100);
		chk({31'h0, hwIrq}, 32'h0, "glitch event");
		// Third byte toggles with every enable set
		@(posedge clk) riseIrqEn <= 16'hffff;
		fallIrqEn <= 16'hffff;
		level <= 24'hff0000;
		idle(LONG + 100);
		chk({31'h0, hwIrq}, 32'h0, "third byte event");
		rd(IN_ADDR_HIGH);
		chk(got, 32'hff, "third input byte");
		// Fast group settles first
		@(posedge clk) riseIrqEn <= 16'h0001;
		fallIrqEn <= 16'h0000;
		level <= 24'hff00ff;
		idle(2560);
		chk({13'h0, hwIrqSrc}, 32'h1, "rise event source");
		rd(IN_ADDR_LOW);
		chk(got, 32'h0f, "fast group only");
		@(posedge clk) irqAck <= 1'b1;
		@(posedge clk) irqAck <= 1'b0;
		idle(600);
		chk({31'h0, hwIrq}, 32'h0, "acknowledged");
		rd(IN_ADDR_LOW);
		chk(got, 32'hff, "slow group settled");
		// Two falling events without acknowledge
		@(posedge clk) fallIrqEn <= 16'h0011;
		level <= 24'hff00ee;
		idle(LONG + 100);
		chk({31'h0, lostSeen}, 32'h1, "lost event");
		chk({13'h0, hwIrqSrc}, 32'h11, "merged sources");
		@(posedge clk) irqAck <= 1'b1;
		{riseIrqEn, fallIrqEn} <= '0;
		level <= 24'h000000;
		@(posedge clk) irqAck <= 1'b0;
		idle(LONG + 100);
		// Gates open one by one: counts 12, 8 and 4 pulses
		for (int c = 0; c < 3; c++) begin
			@(posedge clk) swGate[c] <= 1'b1;
			burst(8'h04);
		end
		for (int c = 0; c < 3; c++) begin
			rd(CNT0_ADDR + 10'(4 * c));
			chk(got, 32'(12 - 4 * c), "free count");
		end
		// Limited modes: periodic up, periodic down, single down
		@(posedge clk) swGate <= 3'h0;
		for (int m = 0; m < 3; m++) begin
			@(posedge clk) cntMode[0] <= (m == 2) ? CNT_SINGLE : CNT_PERIOD;
			mainDir[0] <= (m == 0) ? DIR_UP : DIR_DOWN;
			limitValue[0] <= 32'h5;
			level[1] <= (m != 0);
			repeat (4) @(posedge clk);
			swGate[0] <= 1'b1;
			burst(8'h07);
			rd(CNT0_ADDR);
			chk(got, cnt_exp(m == 2, m != 0, 7), "limited count");
			if (m < 2) @(posedge clk) swGate[0] <= 1'b0;
		end
		@(posedge clk) level[12] <= 1'b1;
		idle(8);
		chk(latchValue[0], cnt_exp(1, 1, 7), "latched value");
		// Counters own their output bits
		for (int c = 0; c < 3; c++) begin
			@(posedge clk) cmpMode <= 6'(CMP_GE) << (2 * c);
			d = 8'($random(seed)) & ~8'(1 << c);
			idle(6);
			wr(OUT_ADDR_LOW, d);
			idle(4);
			chk({24'h0, outPin[7:0]}, {24'h0, d | 8'(1 << c)}, "counter output");
		end
		stop_test;
	end
endmodule // test_digital_io_counter_front_end
